//--- logic/sleep_ctl_pkg.sv
// Constants shared by the sleep-state power control block
package sleep_ctl_pkg;
  // System power states
  typedef enum logic [2:0] {
    PST_S0,
    PST_S0_IDLE,
    PST_S3,
    PST_S4,
    PST_S5,
    PST_DEEP
  } pstate_t;

  // Clock and timing
  localparam int CLK_HZ = 100_000_000;
  localparam int DEBOUNCE_MS = 16;
  localparam int OVERRIDE_S = 4;
  localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam longint OVERRIDE_CYC = longint'(CLK_HZ) * OVERRIDE_S;
  // Delay from active sleep well release to internal power good
  localparam int APG_DELAY_CYC = 16;
  // Strap encodings
  localparam logic WLAN_STRAP_NATIVE = 1'b0;
  localparam logic WLAN_STRAP_GPIO = 1'b1;
endpackage

//--- logic/sleep_power_ctl.sv
// Sleep-state power plane control outputs with power button override
`timescale 1ns/1ps
`default_nettype none

module sleep_power_ctl #(
  parameter int DEBOUNCE_CYC = sleep_ctl_pkg::DEBOUNCE_CYC,
  parameter longint OVERRIDE_CYC = sleep_ctl_pkg::OVERRIDE_CYC,
  parameter int APG_DELAY_CYC = sleep_ctl_pkg::APG_DELAY_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic resume_well_reset_n,
  // Requested state from the power management core, plus idle, deep sleep, well request and WLAN strap/GPIO inputs
  input wire logic [2:0] req_state,
  input wire logic req_valid,
  input wire logic device_idle,
  input wire logic cpu_c10,
  input wire logic deep_sx_enable,
  input wire logic deep_sx_ready,
  input wire logic active_well_req,
  input wire logic wlan_strap,
  input wire logic wlan_gpio_out,
  // Power button
  input wire logic power_button_n,
  // Outputs
  output logic power_button_level_n,
  output logic override_pulse,
  output logic [2:0] cur_state,
  output logic active_sleep_well_n,
  output logic active_well_power_good,
  output logic wired_phy_sleep_n,
  output logic wireless_sleep_n,
  output logic idle_regulator_sleep_n,
  output logic suspend_ram_power_off_n,
  output logic suspend_disk_power_off_n,
  output logic soft_off_power_off_n,
  output logic deep_sleep_n
);
  initial begin
    if (DEBOUNCE_CYC < 1 || OVERRIDE_CYC < 2 || APG_DELAY_CYC < 1 ||
        APG_DELAY_CYC > 65535 || DEBOUNCE_CYC > 2**24 - 1 ||
        OVERRIDE_CYC > 64'h00000000ffffffff) begin
      $error("sleep_power_ctl: unsupported parameter value");
    end
  end

  // Combined reset: resume reset keeps resume logic in reset
  logic rst_n;
  assign rst_n = resetn & resume_well_reset_n;

  ////////////////////////////////////////////////////////////////////////////
  // Power button debounce and override timer

  logic btn_r, btn_nxt;
  logic [23:0] deb_cnt_r, deb_cnt_nxt;
  logic [31:0] hold_cnt_r, hold_cnt_nxt;
  logic ovr_r, ovr_nxt;

  always_comb begin
    btn_nxt = btn_r;
    deb_cnt_nxt = deb_cnt_r;
    if (power_button_n == btn_r) begin
      deb_cnt_nxt = 24'h000000;
    end else if (deb_cnt_r == 24'(DEBOUNCE_CYC - 1)) begin
      btn_nxt = power_button_n;
      deb_cnt_nxt = 24'h000000;
    end else begin
      deb_cnt_nxt = deb_cnt_r + 24'h000001;
    end
    hold_cnt_nxt = hold_cnt_r;
    ovr_nxt = 1'b0;
    if (btn_r) begin
      hold_cnt_nxt = 32'h00000000;
    end else if (hold_cnt_r != 32'(OVERRIDE_CYC)) begin
      hold_cnt_nxt = hold_cnt_r + 32'h00000001;
      ovr_nxt = (hold_cnt_r == 32'(OVERRIDE_CYC - 1));
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_r <= 1'b1;
      deb_cnt_r <= 24'h000000;
      hold_cnt_r <= 32'h00000000;
      ovr_r <= 1'b0;
    end else begin
      btn_r <= btn_nxt;
      deb_cnt_r <= deb_cnt_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      ovr_r <= ovr_nxt;
    end
  end

  assign power_button_level_n = btn_r;
  assign override_pulse = ovr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sleep state tracking

  sleep_ctl_pkg::pstate_t st_r, st_nxt;
  logic ovr_s5_r, ovr_s5_nxt;

  always_comb begin
    st_nxt = st_r;
    ovr_s5_nxt = ovr_s5_r;
    case (st_r)
      sleep_ctl_pkg::PST_S5: begin
        if (ovr_s5_r && deep_sx_enable && deep_sx_ready) begin
          st_nxt = sleep_ctl_pkg::PST_DEEP;
          ovr_s5_nxt = 1'b0;
        end else if (req_valid) begin
          st_nxt = sleep_ctl_pkg::pstate_t'(req_state);
          ovr_s5_nxt = 1'b0;
        end
      end
      default: begin
        if (req_valid) begin
          st_nxt = sleep_ctl_pkg::pstate_t'(req_state);
        end
      end
    endcase
    if (ovr_r) begin
      st_nxt = sleep_ctl_pkg::PST_S5;
      ovr_s5_nxt = 1'b1;
    end
    if (req_state > 3'h5 && req_valid && !ovr_r) begin
      st_nxt = st_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= sleep_ctl_pkg::PST_S5;
      ovr_s5_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ovr_s5_r <= ovr_s5_nxt;
    end
  end

  assign cur_state = st_r;

  ////////////////////////////////////////////////////////////////////////////
  // Output decode and active well power good

  logic asw_r, asw_nxt;
  logic [15:0] apg_cnt_r, apg_cnt_nxt;
  logic apg_r, apg_nxt;
  logic phy_r, phy_nxt;
  logic wlan_r, wlan_nxt;
  logic s0i_r, s0i_nxt;
  logic s3_r, s3_nxt;
  logic s4_r, s4_nxt;
  logic s5_r, s5_nxt;
  logic deep_r, deep_nxt;
  // High once the outputs hold a decoded value rather than reset values
  logic run_r, run_nxt;
  logic in_s0;

  always_comb begin
    in_s0 = (st_nxt == sleep_ctl_pkg::PST_S0) || (st_nxt == sleep_ctl_pkg::PST_S0_IDLE);
    asw_nxt = active_well_req && (st_nxt != sleep_ctl_pkg::PST_DEEP);
    apg_cnt_nxt = apg_cnt_r;
    apg_nxt = 1'b0;
    if (!asw_r) begin
      apg_cnt_nxt = 16'h0000;
    end else if (apg_cnt_r == 16'(APG_DELAY_CYC)) begin
      apg_nxt = 1'b1;
    end else begin
      apg_cnt_nxt = apg_cnt_r + 16'h0001;
    end
    phy_nxt = in_s0 || asw_nxt;
    if (wlan_strap == sleep_ctl_pkg::WLAN_STRAP_GPIO) begin
      wlan_nxt = wlan_gpio_out;
    end else begin
      wlan_nxt = in_s0;
    end
    s0i_nxt = !(st_nxt == sleep_ctl_pkg::PST_S0_IDLE && device_idle && cpu_c10);
    s3_nxt = in_s0;
    s4_nxt = in_s0 || st_nxt == sleep_ctl_pkg::PST_S3;
    s5_nxt = st_nxt != sleep_ctl_pkg::PST_S5 && st_nxt != sleep_ctl_pkg::PST_DEEP;
    deep_nxt = st_nxt != sleep_ctl_pkg::PST_DEEP;
    run_nxt = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // All plane controls asserted while in reset
      asw_r <= 1'b0;
      apg_cnt_r <= 16'h0000;
      apg_r <= 1'b0;
      phy_r <= 1'b0;
      wlan_r <= 1'b0;
      s0i_r <= 1'b0;
      s3_r <= 1'b0;
      s4_r <= 1'b0;
      s5_r <= 1'b0;
      deep_r <= 1'b0;
      run_r <= 1'b0;
    end else begin
      asw_r <= asw_nxt;
      apg_cnt_r <= apg_cnt_nxt;
      apg_r <= apg_nxt;
      phy_r <= phy_nxt;
      wlan_r <= wlan_nxt;
      s0i_r <= s0i_nxt;
      s3_r <= s3_nxt;
      s4_r <= s4_nxt;
      s5_r <= s5_nxt;
      deep_r <= deep_nxt;
      run_r <= run_nxt;
    end
  end

  assign active_sleep_well_n = asw_r;
  assign active_well_power_good = apg_r;
  assign wired_phy_sleep_n = phy_r;
  assign wireless_sleep_n = wlan_r;
  assign idle_regulator_sleep_n = s0i_r;
  assign suspend_ram_power_off_n = s3_r;
  assign suspend_disk_power_off_n = s4_r;
  assign soft_off_power_off_n = s5_r;
  assign deep_sleep_n = deep_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_reset_low: assert property (@(posedge ref_clk) !rst_n |->
    (!suspend_ram_power_off_n && !soft_off_power_off_n && !active_sleep_well_n))
    else $error("outputs not asserted in reset");
  chk_phy_s0: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cur_state <= 3'(sleep_ctl_pkg::PST_S0_IDLE) || active_sleep_well_n)
    |-> wired_phy_sleep_n)
    else $error("wired phy sleep asserted in S0 or with well powered");
  chk_wlan_s0: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cur_state == 3'(sleep_ctl_pkg::PST_S0) &&
    wlan_strap == sleep_ctl_pkg::WLAN_STRAP_NATIVE && $stable(wlan_strap))
    |-> wireless_sleep_n)
    else $error("wireless sleep asserted in S0");
  chk_s3_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
    suspend_ram_power_off_n == (cur_state <= 3'(sleep_ctl_pkg::PST_S0_IDLE)))
    else $error("ram power-off decode wrong");
  chk_s4_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
    suspend_disk_power_off_n == (cur_state <= 3'(sleep_ctl_pkg::PST_S3)))
    else $error("disk power-off decode wrong");
  chk_s5_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cur_state == 3'(sleep_ctl_pkg::PST_S5)) |-> !soft_off_power_off_n)
    else $error("soft-off output not asserted in S5");
  chk_deep_ind: assert property (@(posedge ref_clk) disable iff (!rst_n)
    run_r |-> deep_sleep_n == (cur_state != 3'(sleep_ctl_pkg::PST_DEEP)))
    else $error("deep sleep indication wrong");
  chk_override_s5: assert property (@(posedge ref_clk) disable iff (!rst_n)
    override_pulse |=> (cur_state == 3'(sleep_ctl_pkg::PST_S5)))
    else $error("override did not force S5");
  chk_apg_delay: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(active_sleep_well_n) |-> !active_well_power_good[*2])
    else $error("power good too early");
  chk_idle_sleep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    run_r && !idle_regulator_sleep_n |-> $past(device_idle && cpu_c10))
    else $error("idle sleep without idle and C10");
  chk_debounce: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(power_button_level_n) |-> $past(power_button_n) == power_button_level_n)
    else $error("debounced level not from input");
  chk_idle_state: assert property (@(posedge ref_clk) disable iff (!rst_n)
    run_r && !idle_regulator_sleep_n |-> cur_state == 3'(sleep_ctl_pkg::PST_S0_IDLE))
    else $error("idle sleep outside idle state");
  chk_wlan_gpio: assert property (@(posedge ref_clk) disable iff (!rst_n)
    run_r && wlan_strap == sleep_ctl_pkg::WLAN_STRAP_GPIO &&
    $past(wlan_strap) == sleep_ctl_pkg::WLAN_STRAP_GPIO
    |-> wireless_sleep_n == $past(wlan_gpio_out))
    else $error("wireless pin not following gpio value");
  chk_deep_after_ovr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    override_pulse ##1 (deep_sx_enable && deep_sx_ready && !req_valid)
    |=> cur_state == 3'(sleep_ctl_pkg::PST_DEEP))
    else $error("no deep sleep entry after override");
  chk_good_needs_well: assert property (@(posedge ref_clk) disable iff (!rst_n)
    active_well_power_good |-> $past(active_sleep_well_n))
    else $error("power good without active well");
  chk_well_off_deep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    run_r && cur_state == 3'(sleep_ctl_pkg::PST_DEEP) |-> !active_sleep_well_n)
    else $error("active well on in deep sleep");
  chk_override_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
    override_pulse |=> !override_pulse)
    else $error("override pulse longer than one cycle");
  chk_disk_ram: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !suspend_disk_power_off_n |-> !suspend_ram_power_off_n)
    else $error("disk power-off without ram power-off");
endmodule

`default_nettype wire

//--- test/platform_rails.sv
// Platform side model: well status hold time and resume well reset
`timescale 1ns/1ps
`default_nettype none

module platform_rails #(
  parameter int HOLD_CYC = 5
) (
  // Clock and well status
  input wire logic ref_clk,
  input wire logic wells_valid,
  // Reset to the device
  output logic resume_well_reset_n
);
  int cnt = 0;
  logic rst_q = 1'b0;

  assign resume_well_reset_n = rst_q;

  // Release only after the wells have stayed valid for the hold time
  always @(posedge ref_clk) begin
    if (!wells_valid) begin
      cnt <= 0;
      rst_q <= 1'b0;
    end else if (cnt < HOLD_CYC) begin
      cnt <= cnt + 1;
    end else begin
      rst_q <= 1'b1;
    end
  end
endmodule

`default_nettype wire

//--- test/sleep_state_power_controls_test.sv
// Testbench for the sleep-state power control block
`timescale 1ns/1ps
`default_nettype none

module sleep_state_power_controls_test;
  localparam int APG = 8;
  localparam int DEB = 4;
  localparam int OVR = 20;
  typedef struct packed {logic [2:0] st; logic idl; logic c10; logic [7:0] e; logic [7:0] m;} row_t;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic wells_valid = 1'b1;
  logic resume_well_reset_n;
  logic [2:0] req_state = 3'h0;
  logic req_valid = 1'b0, device_idle = 1'b0, cpu_c10 = 1'b0, deep_sx_enable = 1'b0;
  logic deep_sx_ready = 1'b0, active_well_req = 1'b0, wlan_strap = 1'b0, wlan_gpio_out = 1'b0;
  logic power_button_n = 1'b1;
  logic power_button_level_n, override_pulse, active_sleep_well_n, active_well_power_good;
  logic wired_phy_sleep_n, wireless_sleep_n, idle_regulator_sleep_n, suspend_ram_power_off_n;
  logic suspend_disk_power_off_n, soft_off_power_off_n, deep_sleep_n;
  logic [2:0] cur_state;
  logic [7:0] outs;
  int mismatches = 0, compares = 0, cycles = 0, n;
  row_t rows [9] = '{'{3'h0, 1'b0, 1'b0, 8'h7f, 8'h7f}, '{3'h1, 1'b1, 1'b1, 8'h7d, 8'h7f},
    '{3'h1, 1'b1, 1'b0, 8'h7f, 8'h7f}, '{3'h1, 1'b0, 1'b1, 8'h7f, 8'h7f},
    '{3'h2, 1'b1, 1'b1, 8'h1e, 8'h3e}, '{3'h3, 1'b0, 1'b0, 8'h0e, 8'h3e},
    '{3'h4, 1'b0, 1'b0, 8'h06, 8'h3e}, '{3'h5, 1'b0, 1'b0, 8'h02, 8'h3e},
    '{3'h0, 1'b0, 1'b0, 8'h7f, 8'h7f}};

  assign outs = {active_sleep_well_n, wired_phy_sleep_n, suspend_ram_power_off_n,
    suspend_disk_power_off_n, soft_off_power_off_n, deep_sleep_n, idle_regulator_sleep_n,
    wireless_sleep_n};

  platform_rails rails (.ref_clk, .wells_valid, .resume_well_reset_n);

  sleep_power_ctl #(.DEBOUNCE_CYC(DEB), .OVERRIDE_CYC(OVR), .APG_DELAY_CYC(APG)) uut (
    .ref_clk, .resetn, .resume_well_reset_n, .req_state, .req_valid, .device_idle, .cpu_c10,
    .deep_sx_enable, .deep_sx_ready, .active_well_req, .wlan_strap, .wlan_gpio_out,
    .power_button_n, .power_button_level_n, .override_pulse, .cur_state, .active_sleep_well_n,
    .active_well_power_good, .wired_phy_sleep_n, .wireless_sleep_n, .idle_regulator_sleep_n,
    .suspend_ram_power_off_n, .suspend_disk_power_off_n, .soft_off_power_off_n, .deep_sleep_n);

  always #5 ref_clk = ~ref_clk;

  task automatic complete_run;
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp,
    input logic [7:0] msk = 8'hff);
    compares++;
    if ((seen & msk) !== (exp & msk)) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp & msk, seen & msk);
    end
  endtask

  task automatic request(input logic [2:0] st);
    @(negedge ref_clk);
    req_state = st;
    req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask

  // Wait on a design or platform model output at falling edges, bounded
  task automatic await(ref logic sig, input logic lvl);
    n = 0;
    while (sig !== lvl && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  initial begin
    repeat (2) @(negedge ref_clk);
    check("reset outs", outs, 8'h00);
    check("reset state", {5'h0, cur_state}, 8'h04);
    check("reset good", {7'h0, active_well_power_good}, 8'h00);
    @(negedge ref_clk);
    resetn = 1'b1;
    await(resume_well_reset_n, 1'b1);
    @(negedge ref_clk);
    check("s5 outs", outs, 8'h06, 8'h3e);
    foreach (rows[i]) begin
      device_idle = rows[i].idl;
      cpu_c10 = rows[i].c10;
      request(rows[i].st);
      check("row state", {5'h0, cur_state}, {5'h0, rows[i].st});
      check("row outs", outs, rows[i].e, rows[i].m);
    end
    request(3'h7);
    check("bad code", {5'h0, cur_state}, 8'h00);
    wlan_strap = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("gpio low", {7'h0, wireless_sleep_n}, 8'h00);
    wlan_strap = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("native", {7'h0, wireless_sleep_n}, 8'h01);
    active_well_req = 1'b1;
    await(active_sleep_well_n, 1'b1);
    check("well on", {7'h0, active_sleep_well_n}, 8'h01);
    repeat (APG) @(negedge ref_clk);
    check("good early", {7'h0, active_well_power_good}, 8'h00);
    @(negedge ref_clk);
    check("good late", {7'h0, active_well_power_good}, 8'h01);
    check("phy on", {7'h0, wired_phy_sleep_n}, 8'h01);
    request(3'h2);
    check("phy well", {7'h0, wired_phy_sleep_n}, 8'h01);
    active_well_req = 1'b0;
    await(active_sleep_well_n, 1'b0);
    repeat (2) @(negedge ref_clk);
    check("good drop", {7'h0, active_well_power_good}, 8'h00);
    request(3'h2);
    deep_sx_enable = 1'b1;
    deep_sx_ready = 1'b1;
    power_button_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    power_button_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    check("glitch", {7'h0, power_button_level_n}, 8'h01);
    power_button_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    check("debounce", {7'h0, power_button_level_n}, 8'h01);
    await(power_button_level_n, 1'b0);
    check("debounce time", 8'(n), 8'h01);
    await(override_pulse, 1'b1);
    check("hold time", 8'(n), 8'(OVR));
    @(negedge ref_clk);
    check("override", {5'h0, cur_state}, 8'h04);
    power_button_n = 1'b1;
    await(deep_sleep_n, 1'b0);
    check("deep entry", {5'h0, cur_state}, 8'h05);
    request(3'h0);
    check("deep exit", {7'h0, deep_sleep_n}, 8'h01);
    wells_valid = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("resume rst", outs, 8'h00);
    wells_valid = 1'b1;
    await(resume_well_reset_n, 1'b1);
    @(negedge ref_clk);
    check("rst state", {5'h0, cur_state}, 8'h04);
    complete_run();
  end
endmodule

`default_nettype wire
